// [verilog/spi_ctrl_pkg.sv]
// Purpose: Shared constants and types for the serial peripheral controller.
// Assumes: APB slave with 32-bit data, one word per register.
// Notes:   Offsets are byte addresses on the APB side.
package spi_ctrl_pkg;

	// ============================================================
	// Register map
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_RXD    = 8'h08;
	localparam logic [7:0] ADDR_TXD    = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IER    = 8'h14;
	localparam logic [7:0] ADDR_IDR    = 8'h18;
	localparam logic [7:0] ADDR_IMR    = 8'h1C;
	localparam logic [7:0] ADDR_STCLR  = 8'h20;
	localparam logic [3:0] CSR_PAGE    = 4'h3;

	// ============================================================
	// Field positions
	localparam int CTRL_EN        = 0;
	localparam int CTRL_DIS       = 1;
	localparam int TXD_SEL_LSB    = 16;
	localparam int TXD_LAST       = 24;
	localparam int SRC_RX_FULL    = 0;
	localparam int SRC_TX_FREE    = 1;
	localparam int SRC_OVERRUN    = 3;
	localparam int SRC_SEL_RISE   = 8;
	localparam int SRC_TX_IDLE    = 9;
	localparam int STAT_ENABLED   = 16;
	localparam int NUM_SRC        = 10;
	localparam int CSR_POL        = 0;
	localparam int CSR_PHASE      = 1;
	localparam int CSR_HOLD       = 3;
	localparam int CSR_BITS_LSB   = 4;
	localparam int CSR_DIV_LSB    = 8;
	localparam int CSR_PRE_LSB    = 16;
	localparam int CSR_GAP_LSB    = 24;

	// ============================================================
	// Reset values and counts
	localparam logic [31:0] CSR_RESET  = 32'h0000_0000;
	localparam logic [9:0]  MASK_RESET = 10'h000;
	localparam logic [4:0]  BASE_BITS  = 5'h08;
	localparam logic [4:0]  WORD_BITS  = 5'h10;
	localparam logic [12:0] GAP_MULT   = 13'h0020;

	// ============================================================
	// Character sequencer states
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_PRE   = 4'b0010,
		ST_SHIFT = 4'b0100,
		ST_GAP   = 4'b1000
	} xfer_state_t;

endpackage : spi_ctrl_pkg

// [verilog/spi_ctrl.sv]
// Purpose: Serial peripheral master with interrupt mask and per-select timing.
// Assumes: Single clock at 250 MHz; miso and slaveSelectIn are asynchronous pins.
// Notes:   Four direct select lines, active low; one character in the holding register.
// Summary of operation
// - The transmit-idle flag drops on a holding-register write while enabled and rises when holding register, shifter and gap are all done.
// - The enabled status flag reads one while the interface is enabled and zero otherwise.
// - Enable, disable and mask share a ten-source layout, and a one written to enable sets the mask bit.
// - A one written to the disable register clears the matching mask bit, a zero does nothing.
// - The mask register reads one for each enabled source.
// - Bit 0 of a select configuration sets the resting level of the serial clock.
// - Phase zero changes data on the leading edge and samples on the trailing one; phase one the reverse.
// - Without select hold the select rises after the last transfer, with it the select stays until another select is used or a character marked last ends.
// - The four-bit length code gives 8 to 16 bits per character, and codes above 1000 are not used.
// - The serial clock is the master clock divided by the baud divisor from a modulus counter.
// - The baud divisor resets to zero, and a transfer with a zero divisor is undefined.
// - Select to first clock edge is half the serial period of the select used last (select 0 after reset) for a zero pre-clock field, else that many clocks.
// - A zero inter-character field gives back-to-back characters, else a gap of 32 clocks per count.
// - The inter-character gap follows every character, also before the select is released.
// - The select-rising flag sets on a rising slave select edge and clears on a status read.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
module spi_ctrl
	import spi_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             sclkOut,
	output logic      [3:0]  selectN,
	output logic             mosi,
	input  wire logic        miso,
	input  wire logic        slaveSelectIn,
	output logic             irq
);
	import spi_ctrl_pkg::*;

	// ============================================================
	// Declarations
	xfer_state_t stateQ;
	logic [31:0] csrQ [4];
	logic [9:0]  maskQ;
	logic        enabledQ, holdValidQ, holdLastQ, lastQ, selActiveQ;
	logic [15:0] holdDataQ, shiftQ, rxQ, rxDataQ;
	logic [1:0]  holdSelQ, selIdxQ;
	logic        rxFullQ, overrunQ, selRiseQ, sclkQ, mosiQ;
	logic [7:0]  divCntQ, preCycQ;
	logic [5:0]  edgeCntQ;
	logic [12:0] delayCntQ;
	logic [1:0]  misoSync, ssSync;
	logic        ssPrevQ;
	logic [31:0] prdataQ;
	logic        pslverrQ;

	logic        setup, access, wrEn, rdEn;
	logic [31:0] cfg;
	logic        curPol, curPhase, curHold;
	logic [4:0]  curBits;
	logic [7:0]  curDiv, halfA, halfB, curPre;
	logic [12:0] gapLoad;
	logic [15:0] loadVal;
	logic [5:0]  lastIdx;
	logic        edgeEv, leading, lastEdge, endGo, contNext, takeIdle, take;
	logic        charDone, txIdle, selRise;
	logic [9:0]  statVec;
	logic [15:0] rxNext;

	// ============================================================
	// APB decode
	// The slave never stalls, so every access completes in its first access cycle.
	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign wrEn   = access && pwrite;
	assign rdEn   = access && !pwrite;
	assign pready = 1'b1;
	assign prdata = prdataQ;
	assign pslverr = pslverrQ && access;

	// Current select configuration drives the timing of the active character; a zero pre-clock delay uses the select used last.
	assign cfg      = csrQ[selIdxQ];
	assign curPol   = cfg[CSR_POL];
	assign curPhase = cfg[CSR_PHASE];
	assign curHold  = cfg[CSR_HOLD];
	assign curBits  = BASE_BITS + {1'b0, cfg[CSR_BITS_LSB +: 4]};
	assign curDiv   = cfg[CSR_DIV_LSB +: 8];
	assign curPre   = cfg[CSR_PRE_LSB +: 8];
	// Odd divisors give the longer half to the trailing phase; a divisor of one
	// cannot toggle twice per clock and so runs at half the requested rate.
	assign halfA    = (curDiv[7:1] == 7'h00) ? 8'h01 : {1'b0, curDiv[7:1]};
	assign halfB    = (curDiv <= halfA) ? 8'h01 : 8'(curDiv - halfA);
	assign gapLoad  = 13'(cfg[CSR_GAP_LSB +: 8]) * GAP_MULT;
	assign lastIdx  = 6'({curBits, 1'b0} - 6'h01);
	assign loadVal  = holdDataQ << (WORD_BITS - BASE_BITS - {1'b0, csrQ[holdSelQ][7:4]});

	// ============================================================
	// Sequencer events
	assign edgeEv   = (stateQ == ST_SHIFT) && (divCntQ == 8'h01);
	assign leading  = !edgeCntQ[0];
	assign lastEdge = edgeEv && (edgeCntQ == lastIdx);
	assign charDone = lastEdge;
	// A character ends at its last edge when no gap is set, otherwise after the gap.
	assign endGo    = (lastEdge && gapLoad == 13'h0000) ||
	                  (stateQ == ST_GAP && delayCntQ == 13'h0001);
	assign contNext = holdValidQ && (holdSelQ == selIdxQ) && !lastQ;
	assign takeIdle = (stateQ == ST_IDLE) && holdValidQ &&
	                  !(selActiveQ && selIdxQ != holdSelQ);
	assign take     = enabledQ && (takeIdle || (endGo && contNext));
	assign rxNext   = {rxQ[14:0], misoSync[1]};
	assign txIdle   = (stateQ == ST_IDLE) && !holdValidQ;
	assign selRise  = ssSync[1] && !ssPrevQ;

	// Unimplemented sources (fault and buffer chain flags) read as zero.
	always_comb begin
		statVec               = 10'h000;
		statVec[SRC_RX_FULL]  = rxFullQ;
		statVec[SRC_TX_FREE]  = enabledQ && !holdValidQ;
		statVec[SRC_OVERRUN]  = overrunQ;
		statVec[SRC_SEL_RISE] = selRiseQ;
		statVec[SRC_TX_IDLE]  = txIdle;
	end

	// Level interrupt, high while any enabled source is pending.
	assign irq = |(statVec & maskQ);

	// ============================================================
	// Pin synchronisers
	// Both pins are asynchronous, so two flops stand before any logic.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			misoSync <= 2'h0;
			ssSync   <= 2'h3;
			ssPrevQ  <= 1'b1;
		end else begin
			misoSync <= {misoSync[0], miso};
			ssSync   <= {ssSync[0], slaveSelectIn};
			ssPrevQ  <= ssSync[1];
		end
	end

	// ============================================================
	// Control, mask and configuration registers
	// Enable wins over disable only when both land in the same write.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enabledQ <= 1'b0;
		end else if (wrEn && paddr == ADDR_CTRL) begin
			if (pwdata[CTRL_DIS]) begin
				enabledQ <= 1'b0;
			end
			if (pwdata[CTRL_EN]) begin
				enabledQ <= 1'b1;
			end
		end
	end

	// Write-one set and write-one clear of the shared ten-source mask.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			maskQ <= MASK_RESET;
		end else if (wrEn && paddr == ADDR_IER) begin
			maskQ <= maskQ | pwdata[NUM_SRC-1:0];
		end else if (wrEn && paddr == ADDR_IDR) begin
			maskQ <= maskQ & ~pwdata[NUM_SRC-1:0];
		end
	end

	// Per-select configuration; the divisor field resets to zero.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				csrQ[i] <= CSR_RESET;
			end
		end else if (wrEn && paddr[7:4] == CSR_PAGE && paddr[1:0] == 2'h0) begin
			csrQ[paddr[3:2]] <= {pwdata[31:8], pwdata[7:4], pwdata[3], 1'b0, pwdata[1:0]};
		end
	end

	// Holding register; a write while full overwrites the waiting character.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			holdValidQ <= 1'b0;
			holdDataQ  <= 16'h0000;
			holdSelQ   <= 2'h0;
			holdLastQ  <= 1'b0;
		end else if (!enabledQ) begin
			holdValidQ <= 1'b0;
		end else if (wrEn && paddr == ADDR_TXD) begin
			holdValidQ <= 1'b1;
			holdDataQ  <= pwdata[15:0];
			holdSelQ   <= pwdata[TXD_SEL_LSB +: 2];
			holdLastQ  <= pwdata[TXD_LAST];
		end else if (take) begin
			holdValidQ <= 1'b0;
		end
	end

	// ============================================================
	// Status flags
	// Hardware set wins over a read or write-one clear in the same cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxFullQ  <= 1'b0;
			overrunQ <= 1'b0;
			selRiseQ <= 1'b0;
			rxDataQ  <= 16'h0000;
		end else begin
			if (rdEn && paddr == ADDR_RXD) begin
				rxFullQ <= 1'b0;
			end
			if (rdEn && paddr == ADDR_STATUS) begin
				overrunQ <= 1'b0;
				selRiseQ <= 1'b0;
			end
			if (wrEn && paddr == ADDR_STCLR) begin
				if (pwdata[SRC_OVERRUN]) begin
					overrunQ <= 1'b0;
				end
				if (pwdata[SRC_SEL_RISE]) begin
					selRiseQ <= 1'b0;
				end
			end
			// The flag sets when a character completes with rxFullQ still set, even if the receive data is read in the same cycle.
			if (charDone) begin
				rxFullQ  <= 1'b1;
				rxDataQ  <= curPhase ? rxQ : rxNext;
				if (rxFullQ) begin
					overrunQ <= 1'b1;
				end
			end
			if (selRise) begin
				selRiseQ <= 1'b1;
			end
		end
	end

	// ============================================================
	// Character sequencer
	// One process owns the pins so select, clock and data never disagree.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stateQ     <= ST_IDLE;
			selIdxQ    <= 2'h0;
			selActiveQ <= 1'b0;
			lastQ      <= 1'b0;
			shiftQ     <= 16'h0000;
			rxQ        <= 16'h0000;
			sclkQ      <= 1'b0;
			mosiQ      <= 1'b0;
			divCntQ    <= 8'h01;
			edgeCntQ   <= 6'h00;
			delayCntQ  <= 13'h0001;
		end else if (!enabledQ) begin
			stateQ     <= ST_IDLE;
			selActiveQ <= 1'b0;
			sclkQ      <= curPol;
		end else begin
			case (stateQ)
				ST_IDLE: begin
					sclkQ <= curPol;
					if (holdValidQ && selActiveQ && selIdxQ != holdSelQ) begin
						selActiveQ <= 1'b0;
					end else if (take && selActiveQ) begin
						lastQ    <= holdLastQ;
						rxQ      <= 16'h0000;
						divCntQ  <= halfA;
						edgeCntQ <= 6'h00;
						stateQ   <= ST_SHIFT;
						if (curPhase) begin
							mosiQ  <= loadVal[15];
							shiftQ <= loadVal << 1;
						end else begin
							shiftQ <= loadVal;
						end
					end else if (take) begin
						selIdxQ    <= holdSelQ;
						selActiveQ <= 1'b1;
						lastQ      <= holdLastQ;
						shiftQ     <= loadVal;
						rxQ        <= 16'h0000;
						stateQ     <= ST_PRE;
						sclkQ      <= csrQ[holdSelQ][CSR_POL];
						// Phase one puts the first bit out with the select, ahead of the first edge.
						if (csrQ[holdSelQ][CSR_PHASE]) begin
							mosiQ  <= loadVal[15];
							shiftQ <= loadVal << 1;
						end
						delayCntQ  <= (csrQ[holdSelQ][CSR_PRE_LSB +: 8] == 8'h00) ?
						              13'(halfA) : 13'(csrQ[holdSelQ][CSR_PRE_LSB +: 8]);
					end
				end
				ST_PRE: begin
					sclkQ <= curPol;
					// The first edge closes the delay itself, so no extra half period follows.
					if (delayCntQ == 13'h0001) begin
						sclkQ    <= !curPol;
						divCntQ  <= halfB;
						edgeCntQ <= 6'h01;
						stateQ   <= ST_SHIFT;
						if (curPhase) begin
							rxQ <= rxNext;
						end else begin
							mosiQ  <= shiftQ[15];
							shiftQ <= shiftQ << 1;
						end
					end else begin
						delayCntQ <= delayCntQ - 13'h0001;
					end
				end
				ST_SHIFT: begin
					if (edgeEv) begin
						sclkQ    <= !sclkQ;
						edgeCntQ <= edgeCntQ + 6'h01;
						divCntQ  <= leading ? halfB : halfA;
						// Phase one samples on leading edges, phase zero on trailing.
						if (leading == curPhase) begin
							rxQ <= rxNext;
						end else if (!lastEdge) begin
							mosiQ  <= shiftQ[15];
							shiftQ <= shiftQ << 1;
						end
					end else begin
						divCntQ <= divCntQ - 8'h01;
					end
					if (lastEdge && gapLoad != 13'h0000) begin
						stateQ    <= ST_GAP;
						delayCntQ <= gapLoad;
					end
				end
				ST_GAP: begin
					sclkQ <= curPol;
					if (delayCntQ != 13'h0001) begin
						delayCntQ <= delayCntQ - 13'h0001;
					end
				end
				default: begin
					stateQ <= ST_IDLE;
				end
			endcase
			// Back-to-back characters keep the clock duty cycle when no gap is set.
			if (endGo && take) begin
				lastQ    <= holdLastQ;
				rxQ      <= 16'h0000;
				divCntQ  <= halfA;
				edgeCntQ <= 6'h00;
				stateQ   <= ST_SHIFT;
				if (curPhase) begin
					mosiQ  <= loadVal[15];
					shiftQ <= loadVal << 1;
				end else begin
					shiftQ <= loadVal;
				end
			end else if (endGo) begin
				stateQ     <= ST_IDLE;
				selActiveQ <= curHold && !lastQ;
			end
		end
	end

	assign sclkOut = sclkQ;
	assign mosi    = mosiQ;
	assign selectN = selActiveQ ? ~(4'h1 << selIdxQ) : 4'hF;

	// ============================================================
	// Read data and error, captured in the setup cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdataQ  <= 32'h0000_0000;
			pslverrQ <= 1'b0;
		end else if (setup) begin
			prdataQ  <= 32'h0000_0000;
			pslverrQ <= 1'b0;
			case (paddr)
				ADDR_CTRL, ADDR_TXD, ADDR_IER, ADDR_IDR, ADDR_STCLR: begin
					prdataQ <= 32'h0000_0000;
				end
				ADDR_RXD: begin
					prdataQ <= {14'h0000, selIdxQ, rxDataQ};
				end
				ADDR_STATUS: begin
					prdataQ <= {15'h0000, enabledQ, 6'h00, statVec};
				end
				ADDR_IMR: begin
					prdataQ <= {22'h000000, maskQ};
				end
				default: begin
					if (paddr[7:4] == CSR_PAGE && paddr[1:0] == 2'h0) begin
						prdataQ <= csrQ[paddr[3:2]];
					end else begin
						pslverrQ <= 1'b1;
					end
				end
			endcase
		end
	end

	// ============================================================
	// Checks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			preCycQ <= 8'h00;
		end else begin
			preCycQ <= (stateQ == ST_PRE) ? preCycQ + 8'h01 : 8'h00;
		end
	end

	a_idle_clear: assert property (@(posedge clk) disable iff (rst)
		wrEn && paddr == ADDR_TXD && enabledQ |=> !statVec[SRC_TX_IDLE])
		else $error("transmit idle still set after holding write");
	a_enable_status: assert property (@(posedge clk) disable iff (rst)
		wrEn && paddr == ADDR_CTRL && pwdata[CTRL_EN] |=> enabledQ)
		else $error("enabled flag not set after enable");
	a_mask_set: assert property (@(posedge clk) disable iff (rst)
		wrEn && paddr == ADDR_IER |=> (maskQ & $past(pwdata[9:0])) == $past(pwdata[9:0]))
		else $error("mask bit not set by enable write");
	a_mask_clear: assert property (@(posedge clk) disable iff (rst)
		wrEn && paddr == ADDR_IDR |=> (maskQ & $past(pwdata[9:0])) == 10'h000 &&
		(maskQ | $past(pwdata[9:0])) == ($past(maskQ) | $past(pwdata[9:0])))
		else $error("disable write hit wrong mask bits");
	a_mask_read: assert property (@(posedge clk) disable iff (rst)
		setup && !pwrite && paddr == ADDR_IMR ##1 access |-> prdata[9:0] == $past(maskQ))
		else $error("mask readback wrong");
	a_irq_level: assert property (@(posedge clk) disable iff (rst)
		selRiseQ && maskQ[SRC_SEL_RISE] |-> irq)
		else $error("interrupt missing for enabled source");
	a_clock_rest: assert property (@(posedge clk) disable iff (rst)
		stateQ == ST_PRE ##1 stateQ == ST_PRE |-> sclkOut == curPol)
		else $error("serial clock not at resting level");
	a_pre_delay: assert property (@(posedge clk) disable iff (rst)
		stateQ == ST_PRE ##1 stateQ == ST_SHIFT |->
		$past(preCycQ) + 8'h01 == ((curPre == 8'h00) ? halfA : curPre))
		else $error("pre-clock delay length wrong");
	a_select_release: assert property (@(posedge clk) disable iff (rst)
		endGo && !take && (!curHold || lastQ) |=> selectN == 4'hF)
		else $error("select not released after last character");
	a_gap_hold: assert property (@(posedge clk) disable iff (rst)
		stateQ == ST_GAP |-> selectN != 4'hF)
		else $error("select dropped during inter-character gap");

endmodule : spi_ctrl

// [tb/spi_peer_model.sv]
// Purpose: Behavioural serial peripheral on select line 0, for the controller bench.
// Assumes: The bench sets polarity, phase and length to match the select configuration.
// Notes:   Edges are found by sampling the serial clock with the system clock.
`timescale 1ns/1ns
module spi_peer_model (
	input  wire logic        clk,
	input  wire logic        sclk,
	input  wire logic        selN,
	input  wire logic        mosi,
	input  wire logic        pol,
	input  wire logic        phase,
	input  wire logic [4:0]  nbits,
	input  wire logic [15:0] resp,
	output logic             miso,
	output logic      [15:0] rxWord
);
	// ============================================================
	// Edge tracking
	logic        sclkPrev = 1'b0;
	logic        selPrev  = 1'b1;
	logic [15:0] shiftIn  = 16'h0000;
	int          outIdx   = 0;
	int          inIdx    = 0;

	initial miso = 1'b0;
	initial rxWord = 16'h0000;

	// A released line toggles every cycle, so sampling it when deselected gives no stable value.
	always @(posedge clk) begin
		sclkPrev <= sclk;
		selPrev  <= selN;
		if (selN) begin
			miso <= ~miso;
		end else if (selPrev) begin
			outIdx = 0;
			inIdx  = 0;
			miso <= resp[nbits - 5'h01];
		end else if (sclk != sclkPrev) begin
			if ((sclk != pol) == phase) begin
				shiftIn = {shiftIn[14:0], mosi};
				inIdx++;
				if (inIdx == int'(nbits)) begin
					rxWord <= shiftIn;
					inIdx = 0;
				end
			end else begin
				if (phase) outIdx = (outIdx + 1) % int'(nbits);
				miso <= resp[int'(nbits) - 1 - outIdx];
				if (!phase) outIdx = (outIdx + 1) % int'(nbits);
			end
		end
	end
endmodule : spi_peer_model

// [tb/spi_irq_and_char_timing_tb_top.sv]
// Purpose: Self-checking bench for the mask registers, interrupt and character timing.
// Assumes: Zero-wait APB slave; the peer model listens on select line 0.
// Notes:   Timing is measured on registered outputs, so every edge is seen one clock late.
`timescale 1ns/1ns
module spi_irq_and_char_timing_tb_top;
	import spi_ctrl_pkg::*;
	localparam int         DIV  = 10;
	localparam logic [7:0] CFG0 = {CSR_PAGE, 4'h0};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready, pslverr, sclkOut, mosi, miso, irq;
	logic [3:0]  selectN;
	logic        slaveSelectIn = 1'b1;
	logic        peerPol = 1'b0;
	logic        peerPhase = 1'b0;
	logic [4:0]  peerBits = 5'h08;
	logic [15:0] peerResp = 16'hA5C3;
	logic [15:0] peerWord;
	logic        sclkSeen = 1'b0;
	logic [3:0]  selSeen = 4'hF;
	int          sinceSel = 0, sinceEdge = 0, sinceRise = 0, edgeCnt = 0;
	int          firstDly = 0, tailDly = 0, risePer = 0;
	int          errors = 0, n_checks = 0, cycles = 0;

	spi_ctrl spi_ctrl_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sclkOut(sclkOut), .selectN(selectN),
		.mosi(mosi), .miso(miso), .slaveSelectIn(slaveSelectIn), .irq(irq));

	spi_peer_model spi_peer_model_inst (.clk(clk), .sclk(sclkOut), .selN(selectN[0]),
		.mosi(mosi), .pol(peerPol), .phase(peerPhase), .nbits(peerBits),
		.resp(peerResp), .miso(miso), .rxWord(peerWord));

	// ============================================================
	// Clock, watchdog and link monitor
	always #2 clk = ~clk;

	// The ceiling is far above the longest run, so only a hang reaches it.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			close_out();
		end
	end

	// Counts cycles from select fall and from clock edges, for delay and period checks.
	always @(posedge clk) begin
		sclkSeen  <= sclkOut;
		selSeen   <= selectN;
		sinceSel  <= sinceSel + 1;
		sinceEdge <= sinceEdge + 1;
		sinceRise <= sinceRise + 1;
		if (selSeen == 4'hF && selectN != 4'hF) begin
			sinceSel <= 1;
			edgeCnt  <= 0;
		end else if (sclkOut != sclkSeen) begin
			if (edgeCnt == 0) firstDly <= sinceSel;
			edgeCnt   <= edgeCnt + 1;
			sinceEdge <= 1;
			if (sclkOut) begin
				risePer   <= sinceRise;
				sinceRise <= 1;
			end
		end
		if (selSeen != 4'hF && selectN == 4'hF) tailDly <= sinceEdge;
	end

	// ============================================================
	// Bus and compare tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Holds the request until pready is seen high at a rising edge, then releases it.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] r, output logic err);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r       = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) chk("pready", 32'h1, 32'h0);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(a, 1'b0, 32'h0000_0000, r, e);
	endtask : rd

	// ============================================================
	// Scenarios
	task automatic t_reset();
		logic [31:0] r;
		chk("irq at reset", 32'h0, 32'(irq));
		rd(ADDR_IMR, r);
		chk("mask reset", 32'h0, r);
		for (int i = 0; i < 4; i++) begin
			rd(CFG0 + 8'(4 * i), r);
			chk("config reset", CSR_RESET, r);
		end
		rd(ADDR_STATUS, r);
		chk("enabled at reset", 32'h0, 32'(r[STAT_ENABLED]));
	endtask : t_reset

	// Zero writes must leave the mask alone; an unmapped read must be refused.
	task automatic t_mask();
		logic [31:0] r;
		logic        e;
		wr(ADDR_IER, 32'h0000_03FF);
		rd(ADDR_IMR, r);
		chk("mask all set", 32'h3FF, r);
		wr(ADDR_IDR, 32'h0000_0155);
		rd(ADDR_IMR, r);
		chk("mask part clear", 32'h2AA, r);
		wr(ADDR_IER, 32'h0000_0000);
		wr(ADDR_IDR, 32'h0000_0000);
		rd(ADDR_IMR, r);
		chk("mask zero writes", 32'h2AA, r);
		wr(ADDR_IDR, 32'h0000_03FF);
		rd(ADDR_IMR, r);
		chk("mask all clear", 32'h0, r);
		apb(8'h04, 1'b0, 32'h0000_0000, r, e);
		chk("unmapped error", 32'h1, 32'(e));
		chk("unmapped data", 32'h0, r);
	endtask : t_mask

	task automatic t_irq();
		logic [31:0] r;
		rd(ADDR_STATUS, r);
		slaveSelectIn <= 1'b0;
		repeat (4) @(posedge clk);
		slaveSelectIn <= 1'b1;
		repeat (6) @(posedge clk);
		chk("irq while masked", 32'h0, 32'(irq));
		wr(ADDR_IER, 32'h0000_0100);
		@(posedge clk);
		chk("irq raised", 32'h1, 32'(irq));
		rd(ADDR_STATUS, r);
		chk("select rising flag", 32'h1, 32'(r[SRC_SEL_RISE]));
		@(posedge clk);
		chk("irq after read", 32'h0, 32'(irq));
		wr(ADDR_IDR, 32'h0000_03FF);
	endtask : t_irq

	task automatic t_enable(input logic on);
		logic [31:0] r;
		wr(ADDR_CTRL, on ? 32'h1 : 32'h2);
		rd(ADDR_STATUS, r);
		chk("enabled flag", 32'(on), 32'(r[STAT_ENABLED]));
	endtask : t_enable

	// One character on select 0 in mode m: polarity m[0], phase m[1], lengths 8, 9, 10, 16.
	task automatic t_xfer(input int m);
		logic [31:0] r, cfg;
		logic [15:0] msk, tx;
		logic [7:0]  pre, gap;
		logic [3:0]  code;
		int          n, nb, h;
		code = (m == 3) ? 4'h8 : 4'(m);
		pre  = (m == 1) ? 8'h07 : ((m == 3) ? 8'h14 : 8'h00);
		gap  = (m == 1) ? 8'h00 : ((m == 2) ? 8'h02 : 8'h01);
		nb   = 8 + int'(code);
		h    = (pre == 8'h00) ? DIV / 2 : int'(pre);
		msk  = 16'((32'h1 << nb) - 1);
		tx   = 16'h3C96 & msk;
		cfg  = {gap, pre, 8'(DIV), code, 2'b00, m[1], m[0]};
		peerPol   <= m[0];
		peerPhase <= m[1];
		peerBits  <= 5'(nb);
		wr(CFG0, cfg);
		rd(CFG0, r);
		chk("config readback", cfg, r);
		repeat (2) @(posedge clk);
		chk("clock rest level", 32'(m[0]), 32'(sclkOut));
		wr(ADDR_TXD, {16'h0000, tx});
		rd(ADDR_STATUS, r);
		chk("idle cleared", 32'h0, 32'(r[SRC_TX_IDLE]));
		for (n = 0; n < 5000 && edgeCnt != 2 * nb; n++) @(posedge clk);
		if (gap != 8'h00) begin
			rd(ADDR_STATUS, r);
			chk("idle during gap", 32'h0, 32'(r[SRC_TX_IDLE]));
		end
		for (n = 0; n < 5000 && selectN != 4'hF; n++) @(posedge clk);
		repeat (2) @(posedge clk);
		chk("edges per char", 32'(2 * nb), 32'(edgeCnt));
		chk("select delay", 32'h1, 32'(firstDly == h || firstDly == h + 1));
		chk("clock period", 32'(DIV), 32'(risePer));
		chk("release gap", 32'h1, 32'(tailDly >= 32 * gap && tailDly <= 32 * gap + DIV + 4));
		chk("select released", 32'hF, 32'(selectN));
		rd(ADDR_STATUS, r);
		chk("idle set", 32'h1, 32'(r[SRC_TX_IDLE]));
		chk("peer word", 32'(tx), 32'(peerWord & msk));
		rd(ADDR_RXD, r);
		chk("received word", 32'(peerResp & msk), 32'(r[15:0]));
		chk("clock rest after", 32'(m[0]), 32'(sclkOut));
	endtask : t_xfer

	// Select 0 stays low with hold set, until a character goes to select 1.
	task automatic t_hold();
		logic [31:0] r;
		int          n;
		r = 32'h0000_0000;
		peerPol   <= 1'b0;
		peerPhase <= 1'b0;
		peerBits  <= 5'h08;
		wr(CFG0, {16'h0000, 8'(DIV), 8'h08});
		wr(CFG0 + 8'h04, {16'h0000, 8'(DIV), 8'h00});
		wr(ADDR_TXD, 32'h0000_0055);
		rd(ADDR_STATUS, r);
		for (n = 0; n < 200 && r[SRC_TX_IDLE] !== 1'b1; n++) rd(ADDR_STATUS, r);
		chk("select held", 32'hE, 32'(selectN));
		wr(ADDR_TXD, 32'h0000_0066);
		rd(ADDR_STATUS, r);
		for (n = 0; n < 200 && r[SRC_TX_IDLE] !== 1'b1; n++) rd(ADDR_STATUS, r);
		chk("held second char", 32'h66, 32'(peerWord[7:0]));
		chk("select still held", 32'hE, 32'(selectN));
		wr(ADDR_TXD, 32'h0101_0033);
		for (n = 0; n < 500 && selectN[1] !== 1'b0; n++) @(posedge clk);
		chk("select moved", 32'hD, 32'(selectN));
		for (n = 0; n < 2000 && selectN != 4'hF; n++) @(posedge clk);
		chk("select last", 32'hF, 32'(selectN));
	endtask : t_hold

	// ============================================================
	// Verdict and main sequence
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_mask();
		t_irq();
		t_enable(1'b1);
		for (int m = 0; m < 4; m++) t_xfer(m);
		t_hold();
		t_enable(1'b0);
		close_out();
	end
endmodule : spi_irq_and_char_timing_tb_top
